/* File: frc_rx_cfg.sv */
// receive system interface and receive clock configuration
// assumes an axi4-lite master on ref_clk and pins from the backplane
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "frc_rx_cfg_map.svh"
module frc_rx_cfg (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire frc_pkg::frc_pins_t pins,
  input wire frc_pkg::frc_alarm_t alarms,
  output logic rx_data_q,
  output logic rx_frame_marker_q,
  output logic rx_strobe_q,
  output logic tx_signaling_marker_q,
  output logic tx_sig_data_q,
  output logic tx_sig_strobe_q,
  output logic sig_update_en_q,
  output logic dco_ref_sync_q,
  output logic rcv_clock_out_q
);
  import frc_pkg::*;

  // ==========================================================
  // register bus state
  frc_wr_state_t wr_st_q, wr_st_d;
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [7:0] clock_mode_one_q, clock_mode_one_d, system_interface_control_three_q, system_interface_control_three_d, aux_q, aux_d;
  logic [31:0] mask_q, mask_d;
  logic [7:0] stat_w;

  // ==========================================================
  // link state
  frc_pins_t pin_s;
  logic hwy_prev_q, hwy_prev_d, mk_prev_q, mk_prev_d;
  logic [7:0] bit_cnt_q, bit_cnt_d;
  logic rx_data_d, rx_mk_d, rx_stb_d, txm_d, txd_d, txs_d;
  logic upd_d, dco_d, rclk_d, dco_clk;
  logic hwy_rise, hwy_fall, data_edge, mk_edge, alarm_any, slot_on;
  logic mk_restart;
  logic [7:0] cnt_now;
  logic [2:0] arm_q, arm_d;
  logic [31:0] nco_inc;

  frc_sync2 #(.W(5)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .d(pins),
    .q(pin_s)
  );

  frc_nco u_nco (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .inc(nco_inc),
    .clk_out(dco_clk)
  );

  assign stat_w = {2'h0, rcv_clock_out_q, dco_ref_sync_q, sig_update_en_q,
                   alarms.slip, alarms.frame_align_lost, alarms.no_line_signal_alarm};

  // ==========================================================
  // axi4-lite slave and registers
  always_comb begin
    wr_st_d = wr_st_q;
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    clock_mode_one_d = clock_mode_one_q;
    system_interface_control_three_d = system_interface_control_three_q;
    aux_d = aux_q;
    mask_d = mask_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    case (wr_st_q)
      FRC_WR_IDLE: begin
        if (aw_hold_q && w_hold_q) begin
          aw_hold_d = 1'b0;
          w_hold_d = 1'b0;
          bvalid_d = 1'b1;
          bresp_d = 2'b00;
          wr_st_d = FRC_WR_RESP;
          if (awaddr_q == `FRC_OFS_CLOCK_MODE_ONE) begin
            if (wstrb_q[0]) clock_mode_one_d = wdata_q[7:0];
          end else if (awaddr_q == `FRC_OFS_SYSTEM_INTERFACE_CONTROL_THREE) begin
            if (wstrb_q[0]) system_interface_control_three_d = wdata_q[7:0];
          end else if (awaddr_q == `FRC_OFS_AUX) begin
            if (wstrb_q[0]) aux_d = wdata_q[7:0];
          end else if (awaddr_q == `FRC_OFS_MASK) begin
            for (int b = 0; b < 4; b++) begin
              if (wstrb_q[b]) mask_d[b*8 +: 8] = wdata_q[b*8 +: 8];
            end
          end else if (awaddr_q == `FRC_OFS_STAT) begin
            bresp_d = 2'b10;
          end else begin
            bresp_d = 2'b10;
          end
        end
      end
      FRC_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wr_st_d = FRC_WR_IDLE;
        end
      end
      default: wr_st_d = FRC_WR_IDLE;
    endcase
    // one write at a time: no new address or data until response taken
    awready_d = !aw_hold_d && (wr_st_d == FRC_WR_IDLE) && !bvalid_d;
    wready_d = !w_hold_d && (wr_st_d == FRC_WR_IDLE) && !bvalid_d;
    rvalid_d = s_axi_rvalid;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr == `FRC_OFS_CLOCK_MODE_ONE) begin
        rdata_d[7:0] = clock_mode_one_q;
      end else if (s_axi_araddr == `FRC_OFS_SYSTEM_INTERFACE_CONTROL_THREE) begin
        rdata_d[7:0] = system_interface_control_three_q;
      end else if (s_axi_araddr == `FRC_OFS_AUX) begin
        rdata_d[7:0] = aux_q;
      end else if (s_axi_araddr == `FRC_OFS_MASK) begin
        rdata_d = mask_q;
      end else if (s_axi_araddr == `FRC_OFS_STAT) begin
        rdata_d[7:0] = stat_w;
      end else begin
        rresp_d = 2'b10;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_st_q <= FRC_WR_IDLE;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      clock_mode_one_q <= `FRC_RST_BYTE;
      system_interface_control_three_q <= `FRC_RST_BYTE;
      aux_q <= `FRC_RST_BYTE;
      mask_q <= `FRC_RST_MASK;
    end else begin
      wr_st_q <= wr_st_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      clock_mode_one_q <= clock_mode_one_d;
      system_interface_control_three_q <= system_interface_control_three_d;
      aux_q <= aux_d;
      mask_q <= mask_d;
    end
  end

  // ==========================================================
  // receive system side, pcm highway clock sampled on ref_clk
  always_comb begin
    // no edges until the synchroniser holds the true pin level
    arm_d = {arm_q[1:0], 1'b1};
    hwy_rise = arm_q[2] && pin_s.hwy_clk && !hwy_prev_q;
    hwy_fall = arm_q[2] && !pin_s.hwy_clk && hwy_prev_q;
    data_edge = system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_RECEIVE_EDGE_SELECT] ? hwy_rise : hwy_fall;
    // inversion swaps marker sense against the data edge
    mk_edge = (system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_RECEIVE_EDGE_SELECT] ^ aux_q[`FRC_AUX_INVERT_RX_SYNC_PULSE]) ?
              hwy_rise : hwy_fall;
    // marker restarts the frame: its own bit is bit 0 of slot 0
    mk_restart = mk_edge && pin_s.rx_frame_marker && !mk_prev_q;
    cnt_now = mk_restart ? 8'h00 : bit_cnt_q;
    slot_on = system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_FRACTIONAL_SLOT_FUNCTION] && mask_q[cnt_now[7:3]];
    hwy_prev_d = pin_s.hwy_clk;
    mk_prev_d = mk_prev_q;
    bit_cnt_d = cnt_now;
    rx_data_d = rx_data_q;
    rx_mk_d = rx_frame_marker_q;
    rx_stb_d = data_edge;
    txm_d = slot_on;
    txd_d = tx_sig_data_q;
    txs_d = 1'b0;
    if (data_edge) begin
      rx_data_d = pin_s.rx_data;
      bit_cnt_d = cnt_now + 8'h01;
      if (slot_on) begin
        txd_d = pin_s.tx_signaling_input;
        txs_d = 1'b1;
      end
    end
    if (mk_edge) begin
      rx_mk_d = pin_s.rx_frame_marker;
      mk_prev_d = pin_s.rx_frame_marker;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_q <= 3'h0;
      hwy_prev_q <= 1'b0;
      mk_prev_q <= 1'b0;
      bit_cnt_q <= 8'h00;
      rx_data_q <= 1'b0;
      rx_frame_marker_q <= 1'b0;
      rx_strobe_q <= 1'b0;
      tx_signaling_marker_q <= 1'b0;
      tx_sig_data_q <= 1'b0;
      tx_sig_strobe_q <= 1'b0;
    end else begin
      arm_q <= arm_d;
      hwy_prev_q <= hwy_prev_d;
      mk_prev_q <= mk_prev_d;
      bit_cnt_q <= bit_cnt_d;
      rx_data_q <= rx_data_d;
      rx_frame_marker_q <= rx_mk_d;
      rx_strobe_q <= rx_stb_d;
      tx_signaling_marker_q <= txm_d;
      tx_sig_data_q <= txd_d;
      tx_sig_strobe_q <= txs_d;
    end
  end

  // ==========================================================
  // signaling freeze and receive clock source
  always_comb begin
    alarm_any = alarms.no_line_signal_alarm || alarms.frame_align_lost || alarms.slip;
    // disable bit only counts with serial signaling access
    upd_d = !aux_q[`FRC_AUX_FFS] &&
            (!alarm_any || (system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_DAF] &&
             aux_q[`FRC_AUX_SSE]));
    dco_d = aux_q[`FRC_AUX_SLAVE] && alarms.no_line_signal_alarm &&
            !clock_mode_one_q[`FRC_CLOCK_MODE_ONE_DCS];
    if (clock_mode_one_q[`FRC_CLOCK_MODE_ONE_RS_LO]) begin
      nco_inc = aux_q[`FRC_AUX_SCF] ? `FRC_INC_6M176 :
                `FRC_INC_8M192;
    end else begin
      nco_inc = aux_q[`FRC_AUX_SCF] ? `FRC_INC_1M544 :
                `FRC_INC_2M048;
    end
    case (clock_mode_one_q[`FRC_CLOCK_MODE_ONE_RS_LO +: 2])
      2'b00: rclk_d = pin_s.dpll_clk;
      2'b01: rclk_d = alarms.no_line_signal_alarm || pin_s.dpll_clk;
      default: rclk_d = dco_clk;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sig_update_en_q <= 1'b0;
      dco_ref_sync_q <= 1'b0;
      rcv_clock_out_q <= 1'b0;
    end else begin
      sig_update_en_q <= upd_d;
      dco_ref_sync_q <= dco_d;
      rcv_clock_out_q <= rclk_d;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  fall_latch_a: assert property (
    (hwy_fall && !system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_RECEIVE_EDGE_SELECT]) |=>
    (rx_strobe_q && rx_data_q == $past(pin_s.rx_data)))
    else $error("falling edge latch missed");
  rise_latch_a: assert property (
    (hwy_rise && system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_RECEIVE_EDGE_SELECT]) |=> rx_strobe_q)
    else $error("rising edge latch missed");
  marker_sense_a: assert property (
    (hwy_fall && (system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_RECEIVE_EDGE_SELECT] == aux_q[`FRC_AUX_INVERT_RX_SYNC_PULSE])) |=>
    rx_frame_marker_q == $past(pin_s.rx_frame_marker))
    else $error("frame marker edge sense wrong");
  frac_marker_a: assert property (
    !system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_FRACTIONAL_SLOT_FUNCTION] |=> !tx_signaling_marker_q && !tx_sig_strobe_q)
    else $error("fractional marker active while off");
  soft_freeze_a: assert property (
    aux_q[`FRC_AUX_FFS] |=> !sig_update_en_q)
    else $error("software freeze ignored");
  auto_freeze_a: assert property (
    (alarm_any && !system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_DAF]) |=> !sig_update_en_q)
    else $error("alarm did not freeze signaling");
  no_freeze_a: assert property (
    (system_interface_control_three_q[`FRC_SYSTEM_INTERFACE_CONTROL_THREE_DAF] && aux_q[`FRC_AUX_SSE] && !aux_q[`FRC_AUX_FFS])
    |=> sig_update_en_q)
    else $error("signaling frozen with freeze disabled");
  daf_gate_a: assert property (
    (alarm_any && !aux_q[`FRC_AUX_SSE]) |=> !sig_update_en_q)
    else $error("disable bit acted without serial access");
  los_high_a: assert property (
    (clock_mode_one_q[`FRC_CLOCK_MODE_ONE_RS_LO +: 2] == 2'b01 && alarms.no_line_signal_alarm) |=>
    rcv_clock_out_q)
    else $error("receive clock not held high on loss");
  clk_switch_a: assert property (
    (clock_mode_one_q[`FRC_CLOCK_MODE_ONE_DCS]) |=> !dco_ref_sync_q)
    else $error("oscillator switched while disabled");
endmodule

/* File: frc_rx_cfg_map.svh */
// offsets, field positions, reset values and rate constants of the block
// assumes the includer already runs at the 250 MHz reference clock
`ifndef FRC_RX_CFG_MAP_SVH
`define FRC_RX_CFG_MAP_SVH

// ==========================================================
// register byte addresses
`define FRC_ADDR_W 8
`define FRC_OFS_CLOCK_MODE_ONE 8'h44
`define FRC_OFS_SYSTEM_INTERFACE_CONTROL_THREE 8'h48
`define FRC_OFS_AUX 8'h4c
`define FRC_OFS_MASK 8'h50
`define FRC_OFS_STAT 8'h54

// ==========================================================
// field positions
`define FRC_CLOCK_MODE_ONE_RS_LO 4
`define FRC_CLOCK_MODE_ONE_DCS 3
`define FRC_SYSTEM_INTERFACE_CONTROL_THREE_RECEIVE_EDGE_SELECT 0
`define FRC_SYSTEM_INTERFACE_CONTROL_THREE_FRACTIONAL_SLOT_FUNCTION 1
`define FRC_SYSTEM_INTERFACE_CONTROL_THREE_DAF 2
`define FRC_AUX_SCF 0
`define FRC_AUX_FFS 1
`define FRC_AUX_INVERT_RX_SYNC_PULSE 2
`define FRC_AUX_SSE 3
`define FRC_AUX_SLAVE 4

// ==========================================================
// reset values
`define FRC_RST_BYTE 8'h00
`define FRC_RST_MASK 32'h0000_0000

// ==========================================================
// phase increments of the 32-bit de-jitter oscillator at 250 MHz
`define FRC_INC_2M048 32'd35184372
`define FRC_INC_1M544 32'd26525718
`define FRC_INC_8M192 32'd140737488
`define FRC_INC_6M176 32'd106102872

`endif

/* File: frc_pkg.sv */
// types shared by the receive configuration block and its bench
// assumes the constants header is included where offsets are needed
package frc_pkg;

  // ==========================================================
  // alarm inputs from the framer core
  typedef struct packed {
    logic no_line_signal_alarm;
    logic frame_align_lost;
    logic slip;
  } frc_alarm_t;

  // ==========================================================
  // pins of the receive system side, sampled on ref_clk
  typedef struct packed {
    logic hwy_clk;
    logic rx_data;
    logic rx_frame_marker;
    logic tx_signaling_input;
    logic dpll_clk;
  } frc_pins_t;

  // ==========================================================
  // write channel states
  typedef enum logic [1:0] {
    FRC_WR_IDLE = 2'b01,
    FRC_WR_RESP = 2'b10
  } frc_wr_state_t;

endpackage

/* File: frc_sync2.sv */
// two flip-flop synchroniser, one per bit
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/100ps
module frc_sync2 #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // ==========================================================
  // first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_q[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_q[i] <= d[i];
        q[i] <= meta_q[i];
      end
    end
  end
endmodule

/* File: frc_nco.sv */
// phase accumulator making the de-jittered receive clock
// assumes a steady increment; a change takes effect on the next edge
`timescale 1ns/100ps
module frc_nco (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [31:0] inc,
  output logic clk_out
);
  logic [31:0] acc_q;
  logic [31:0] acc_d;

  // ==========================================================
  // accumulator; msb is the square wave, jitter one ref period
  always_comb begin
    acc_d = acc_q + inc;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= 32'h0000_0000;
      clk_out <= 1'b0;
    end else begin
      acc_q <= acc_d;
      clk_out <= acc_d[31];
    end
  end
endmodule

/* File: frc_hwy_model.sv */
// backplane highway model: sends short frames on a 48 ns link clock
// assumes the bench raises go once per frame and waits out busy
`timescale 1ns/100ps
module frc_hwy_model #(
  parameter logic [15:0] PAT = 16'ha5c3
) (
  input wire logic go,
  input wire logic latch_rise,
  input wire logic mk_opp,
  output logic hwy_clk,
  output logic data,
  output logic marker,
  output logic sig_in,
  output logic busy
);
  // ==========================================================
  // frame sender
  initial begin
    hwy_clk = 1'b1;
    data = 1'b0;
    marker = 1'b0;
    sig_in = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #1.3;
      for (int i = 0; i < 24; i++) begin
        // data moves on the edge that is not latched, so no race
        data = PAT[i % 16];
        sig_in = ~PAT[i % 16];
        if (!mk_opp) marker = (i == 0);
        hwy_clk = ~latch_rise;
        #24;
        if (mk_opp) marker = (i == 0);
        hwy_clk = latch_rise;
        #24;
      end
      // clock stands still high; data and sig_in show the inverse, marker low
      hwy_clk = 1'b1;
      data = ~data;
      sig_in = ~sig_in;
      marker = 1'b0;
      busy = 1'b0;
    end
  end
endmodule

/* File: frc_rx_cfg_tb.sv */
// self-checking bench for the receive configuration block
// assumes the highway model drives the backplane pins
`timescale 1ns/100ps
`include "frc_rx_cfg_map.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module frc_rx_cfg_tb;
  import frc_pkg::*;
  localparam logic [15:0] PAT = 16'ha5c3;
  logic ref_clk = 0;
  logic arst_n = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  frc_alarm_t alarms = '0;
  logic dpll = 0, go = 0, lr = 0, mko = 0;
  logic hclk, hdat, hmk, hsig, busy;
  logic [3:0] dcnt = 0;
  logic rxd, rxm, rxs, tsm, tsd, tss, upd, dsync, rclk;
  int error_cnt = 0;
  int compares = 0;

  // ==========================================================
  // clocks and instances
  always #2 ref_clk = ~ref_clk;
  // recovered line clock, slow enough to pass the synchroniser
  always @(posedge ref_clk) begin
    dcnt <= (dcnt == 4'd9) ? 4'd0 : dcnt + 4'd1;
    if (dcnt == 4'd9) dpll <= ~dpll;
  end
  frc_hwy_model #(.PAT(PAT)) hwy (.go(go), .latch_rise(lr), .mk_opp(mko),
    .hwy_clk(hclk), .data(hdat), .marker(hmk), .sig_in(hsig), .busy(busy));
  frc_rx_cfg dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins({hclk, hdat, hmk, hsig, dpll}),
    .alarms(alarms), .rx_data_q(rxd), .rx_frame_marker_q(rxm),
    .rx_strobe_q(rxs), .tx_signaling_marker_q(tsm), .tx_sig_data_q(tsd),
    .tx_sig_strobe_q(tss), .sig_update_en_q(upd), .dco_ref_sync_q(dsync),
    .rcv_clock_out_q(rclk));

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'b00);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er, input string nm);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK(nm, ed, rdata)
    `CHK(nm, er, rresp)
  endtask

  // ==========================================================
  // scenarios
  task automatic freeze_t();
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = i[3:0];
      wr(`FRC_OFS_SYSTEM_INTERFACE_CONTROL_THREE, {29'd0, b[0], 2'b00});
      wr(`FRC_OFS_AUX, {28'd0, b[1], 1'b0, b[2], 1'b0});
      alarms <= b[3] ? frc_alarm_t'(3'b100 >> (i % 3)) : '0;
      repeat (6) @(posedge ref_clk);
      `CHK("update en", ~b[2] & ~(b[3] & ~(b[0] & b[1])), upd)
    end
    for (int i = 0; i < 8; i++) begin
      b = i[3:0];
      alarms <= {b[2], 2'b00};
      wr(`FRC_OFS_AUX, {27'd0, b[0], 4'h0});
      wr(`FRC_OFS_CLOCK_MODE_ONE, {28'd0, b[1], 3'd0});
      repeat (6) @(posedge ref_clk);
      `CHK("sync switch", b[0] & b[2] & ~b[1], dsync)
    end
    $display("freeze and switch test done");
  endtask

  task automatic rclk_t(input logic [1:0] sel, input logic fam,
                        input logic no_line_signal_alarm, input int lo, input int hi);
    int c;
    logic p;
    c = 0;
    alarms <= {no_line_signal_alarm, 2'b00};
    wr(`FRC_OFS_AUX, {31'd0, fam});
    wr(`FRC_OFS_CLOCK_MODE_ONE, {26'd0, sel, 4'h0});
    repeat (20) @(posedge ref_clk);
    p = rclk;
    repeat (2500) begin
      @(posedge ref_clk);
      if (rclk && !p) c++;
      p = rclk;
    end
    `CHK("clock rises in range", 1'b1, c >= lo && c <= hi)
    if (no_line_signal_alarm) `CHK("clock held", 1'b1, rclk)
    $display("clock select %b family %b done", sel, fam);
  endtask

  task automatic frame(input logic receive_edge_select, input logic invert_rx_sync_pulse, input logic frac);
    int k, mk, ts;
    logic mq;
    k = 0;
    mk = 0;
    ts = 0;
    wr(`FRC_OFS_SYSTEM_INTERFACE_CONTROL_THREE, {30'd0, frac, receive_edge_select});
    wr(`FRC_OFS_AUX, {29'd0, invert_rx_sync_pulse, 2'b00});
    wr(`FRC_OFS_MASK, 32'h0000_0001);
    lr <= receive_edge_select;
    mko <= invert_rx_sync_pulse;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    mq = rxm;
    for (int n = 0; n < 12; n++) begin
      @(posedge ref_clk);
      if (busy) n = 0;
      if (rxs) begin
        `CHK("latch edge", receive_edge_select, hclk)
        `CHK("rx data", PAT[k % 16], rxd)
        if (frac && (k == 3 || k == 12)) `CHK("sig mark", k == 3, tsm)
        k++;
      end
      if (rxm && !mq) begin
        mk++;
        `CHK("marker edge", receive_edge_select ^ invert_rx_sync_pulse, hclk)
      end
      mq = rxm;
      if (tss) ts++;
    end
    `CHK("bits", 24, k)
    `CHK("markers", 1, mk)
    if (frac) `CHK("sig samples", 8, ts)
    $display("frame edge %b invert %b done", receive_edge_select, invert_rx_sync_pulse);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(`FRC_OFS_CLOCK_MODE_ONE, 32'h0, 2'b00, "cmr reset");
    rd(`FRC_OFS_SYSTEM_INTERFACE_CONTROL_THREE, 32'h0, 2'b00, "sic reset");
    wr(`FRC_OFS_CLOCK_MODE_ONE, 32'ha7);
    rd(`FRC_OFS_CLOCK_MODE_ONE, 32'ha7, 2'b00, "cmr rw");
    wr(`FRC_OFS_MASK, 32'h1234_5678);
    rd(`FRC_OFS_MASK, 32'h1234_5678, 2'b00, "mask rw");
    wr(`FRC_OFS_STAT, 32'hff, 2'b10);
    wr(8'h60, 32'hff, 2'b10);
    rd(8'h60, 32'h0, 2'b10, "unmapped");
    $display("register test done");
    freeze_t();
    rclk_t(2'b00, 1'b0, 1'b0, 124, 126);
    rclk_t(2'b01, 1'b0, 1'b1, 0, 0);
    rclk_t(2'b01, 1'b0, 1'b0, 124, 126);
    rclk_t(2'b10, 1'b0, 1'b0, 19, 22);
    rclk_t(2'b10, 1'b1, 1'b0, 14, 17);
    rclk_t(2'b11, 1'b0, 1'b0, 81, 83);
    rclk_t(2'b11, 1'b1, 1'b0, 61, 63);
    frame(1'b0, 1'b0, 1'b1);
    frame(1'b1, 1'b0, 1'b0);
    frame(1'b0, 1'b1, 1'b0);
    frame(1'b1, 1'b1, 1'b0);
    tally_and_finish();
  end

  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
